// file: include/eib_pkg.sv
// shared constants and types of the external-to-internal access bridge
package eib_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] EIB_CTRL_OFS   = 8'h00;
  localparam logic [7:0] EIB_EXTCON_OFS = 8'h04;
  localparam logic [7:0] EIB_STAT_OFS   = 8'h08;

  // bridge_control_reg fields
  localparam int EIB_CTRL_ACC_BIT   = 0;
  localparam int EIB_CTRL_PRIV_BIT  = 1;
  localparam int EIB_CTRL_RECON_BIT = 2;
  localparam logic [2:0] EIB_CTRL_RST = 3'h0;

  // extension_control_reg fields
  localparam int EIB_PTR_W        = 10;
  localparam int EIB_PTR_A_LSB    = 0;
  localparam int EIB_PTR_B_LSB    = 10;
  localparam int EIB_PTR_C_LSB    = 20;
  localparam int EIB_LOCK_BIT     = 30;
  localparam logic [9:0] EIB_PTR_A_RST = 10'h000;
  localparam logic [9:0] EIB_PTR_B_RST = 10'h001;
  localparam logic [9:0] EIB_PTR_C_RST = 10'h002;

  // status register fields
  localparam int EIB_STAT_BUSY_BIT   = 0;
  localparam int EIB_STAT_WBUF_BIT   = 1;
  localparam int EIB_STAT_REFUSE_BIT = 2;

  // pointer selection by the top two external address bits
  localparam logic [1:0] EIB_SEL_A   = 2'h0;
  localparam logic [1:0] EIB_SEL_CFG = 2'h1;
  localparam logic [1:0] EIB_SEL_B   = 2'h2;
  localparam logic [1:0] EIB_SEL_C   = 2'h3;

  // internal access width encoding
  localparam logic [1:0] EIB_SZ_BYTE = 2'h0;
  localparam logic [1:0] EIB_SZ_HALF = 2'h1;
  localparam logic [1:0] EIB_SZ_WORD = 2'h2;

  // timing counts
  localparam int EIB_IB_MIN_CYC = 3;
  localparam logic [1:0] EIB_IB_LAST = 2'(EIB_IB_MIN_CYC - 1);

  typedef enum logic [1:0] {
    EIB_IDLE,
    EIB_XFER,
    EIB_INT
  } eib_state_type;

endpackage

// file: testbench/eib_bridge_checker.sv
// port checks of the access bridge
`timescale 1ns/10ps
module eib_bridge_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_we,
  // external bus
  input wire logic        bridge_chip_select_n,
  input wire logic        ext_rd_n,
  input wire logic [31:0] ext_data_out,
  input wire logic        ext_data_oe,
  input wire logic        ext_wait_oe,
  // internal bus and internal task
  input wire logic        ib_req,
  input wire logic        ib_write,
  input wire logic        ib_supervisor,
  input wire logic        ib_lock,
  input wire logic        ib_ack,
  input wire logic [31:0] ib_rdata,
  input wire logic        int_req,
  input wire logic        int_reject
);
  logic [1:0] cnt_q;
  logic       acc_q, sel_q, lock_q;
  logic       done;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // request age, saturating so long waits cannot wrap
  always_ff @(posedge clk) begin
    if (!rstn || !ib_req) begin
      cnt_q <= 2'h0;
    end else if (cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // shadow of control bits; the lock shadow ignores external pointer writes, which also load lock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {acc_q, sel_q, lock_q} <= 3'h0;
    end else if (reg_we && reg_addr == eib_pkg::EIB_CTRL_OFS) begin
      acc_q <= reg_wdata[eib_pkg::EIB_CTRL_ACC_BIT];
      sel_q <= reg_wdata[eib_pkg::EIB_CTRL_PRIV_BIT];
    end else if (reg_we && reg_addr == eib_pkg::EIB_EXTCON_OFS) begin
      lock_q <= reg_wdata[eib_pkg::EIB_LOCK_BIT];
    end
  end
  // an ack only counts from the third request cycle on
  assign done = ib_req && ib_ack && cnt_q >= 2'h2;
  a_req_min_len:
  assert property ($rose(ib_req) |-> ib_req[*3])
    else $error("request shorter than three cycles");
  a_req_held:
  assert property (ib_req && !done |=> ib_req)
    else $error("request dropped before completion");
  a_req_ends:
  assert property (done |=> !ib_req)
    else $error("request kept after completion");
  a_read_data:
  assert property (done && !ib_write |=> ext_data_oe && !ext_wait_oe
                   && ext_data_out == $past(ib_rdata))
    else $error("read data not returned after ack");
  a_read_wait:
  assert property (ib_req && !ib_write |-> ext_wait_oe)
    else $error("no wait during internal read");
  a_read_sync:
  assert property ($rose(ib_req) && !ib_write |->
                   $past(ext_rd_n, 2) == 1'b0
                   && $past(bridge_chip_select_n, 2) == 1'b0)
    else $error("read started before inputs synchronised");
  a_access_enable:
  assert property ($rose(ib_req) |-> acc_q)
    else $error("transfer while access disabled");
  a_priv_select:
  assert property (ib_req && ib_supervisor |-> sel_q)
    else $error("supervisor without privilege select");
  a_lock_copy:
  assert property (ib_lock == $past(lock_q))
    else $error("lock output does not follow lock bit");
  a_reject_busy:
  assert property ($past(ib_req) && !$past(done) && $past(int_req)
                   |-> int_reject)
    else $error("internal request not rejected while busy");
endmodule
bind eib_bridge eib_bridge_checker u_chk (.*);

// file: testbench/eib_bridge_tb_top.sv
// self-checking bench of the access bridge
`timescale 1ns/10ps
module eib_bridge_tb_top;
  typedef struct packed {
    logic wr; logic [1:0] sel; logic [3:0] lane_n; logic [1:0] lo;
    logic [31:0] d; logic [1:0] sz;
  } eib_row_type;
  logic        clk, rstn, reg_we, reg_re, ib_ack, int_req, int_done;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ib_rdata, ext_data_in, ext_data_out;
  logic [31:0] ib_addr, ib_wdata, q, cap_addr, cap_wdata, tgt_rdata;
  logic [23:0] ext_addr;
  logic [3:0]  byte_control_lines_n, ib_be, cap_be;
  logic [1:0]  ib_size, cap_sz;
  logic        bridge_chip_select_n, ext_rd_n, ext_wr_n, ext_wait_out;
  logic        privilege_level_pin, ext_data_oe, ext_wait_oe, ext_bus_own;
  logic        ib_req, ib_write, ib_supervisor, ib_lock, int_grant;
  logic        int_reject, cap_wr, cap_sup, w, w2, rej_seen, req_q;
  int          error_cnt, checks, cyc, n_xfer, x0, tgt_cnt, tgt_lat, i;
  eib_row_type r;
  // every width and lane, through all three pointers
  eib_row_type rows [8] = '{
    '{1'b0, 2'h0, 4'h0, 2'h0, 32'h1234abcd, eib_pkg::EIB_SZ_WORD},
    '{1'b1, 2'h2, 4'h0, 2'h0, 32'h5a5a0f0f, eib_pkg::EIB_SZ_WORD},
    '{1'b1, 2'h3, 4'hc, 2'h0, 32'h0000beef, eib_pkg::EIB_SZ_HALF},
    '{1'b0, 2'h0, 4'h3, 2'h2, 32'hcafe0000, eib_pkg::EIB_SZ_HALF},
    '{1'b1, 2'h2, 4'he, 2'h0, 32'h00000011, eib_pkg::EIB_SZ_BYTE},
    '{1'b0, 2'h3, 4'hd, 2'h1, 32'h00002200, eib_pkg::EIB_SZ_BYTE},
    '{1'b1, 2'h0, 4'hb, 2'h2, 32'h00330000, eib_pkg::EIB_SZ_BYTE},
    '{1'b0, 2'h2, 4'h7, 2'h3, 32'h44000000, eib_pkg::EIB_SZ_BYTE}};
  eib_bridge dut (.*);
  eib_ext_master m (.*);
  always #10 clk = ~clk;
  // internal target: ack after tgt_lat request cycles
  always @(posedge clk) begin
    ib_ack   <= 1'b0;
    ib_rdata <= tgt_rdata;
    tgt_cnt  <= 0;
    if (ib_req === 1'b1 && ib_ack !== 1'b1) begin
      tgt_cnt <= tgt_cnt + 1;
      if (tgt_cnt + 1 >= tgt_lat) ib_ack <= 1'b1;
    end
  end
  // capture each transfer at its first cycle; cut a hang short
  always @(negedge clk) begin
    if (int_reject === 1'b1) rej_seen = 1'b1;
    if (ib_req === 1'b1 && req_q !== 1'b1) begin
      n_xfer++;
      {cap_addr, cap_wr, cap_sz, cap_be, cap_wdata, cap_sup} =
        {ib_addr, ib_write, ib_size, ib_be, ib_wdata, ib_supervisor};
    end
    req_q = ib_req;
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_re} <= {a, 1'b1};
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  function automatic logic [9:0] ptr(input logic [1:0] s);
    return s == 2'h0 ? eib_pkg::EIB_PTR_A_RST :
           s == 2'h2 ? eib_pkg::EIB_PTR_B_RST : eib_pkg::EIB_PTR_C_RST;
  endfunction
  initial begin
    {clk, rstn, reg_we, reg_re, ib_ack, int_req, int_done, req_q} = 8'h0;
    {reg_addr, reg_wdata, ib_rdata, tgt_rdata} = '0;
    {error_cnt, checks, cyc, n_xfer, tgt_cnt} = '0;
    tgt_lat = 3;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("reset_out", {ib_req, ext_data_oe, ext_wait_oe, ext_bus_own,
          int_grant, int_reject, ib_lock, ib_size}, {7'h0, 2'h2});
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd(eib_pkg::EIB_EXTCON_OFS, q);
    check("extcon_rst", q, 32'h00200400);
    reg_rd(8'h0c, q);
    check("unmapped", q, 32'h0);
    // refused while the enable bit is clear
    m.access(1'b1, 1'b0, 1'b0, 24'h012344, 4'h0, 32'h0, q, w);
    check("off_rd", q, 32'h0);
    check("off_xfer", n_xfer, 0);
    reg_rd(eib_pkg::EIB_STAT_OFS, q);
    check("refused", q, 32'h4);
    // refusal flag is write-one-to-clear
    reg_wr(eib_pkg::EIB_STAT_OFS, 32'h4);
    reg_rd(eib_pkg::EIB_STAT_OFS, q);
    check("refuse_clr", q, 32'h0);
    reg_wr(eib_pkg::EIB_CTRL_OFS, 32'h3);
    for (i = 0; i < 8; i++) begin
      r = rows[i];
      tgt_rdata = r.d;
      x0 = n_xfer;
      m.access(1'b1, r.wr, i[0], {r.sel, 20'h12345, r.lo}, r.lane_n, r.d,
               q, w);
      check("xfer", n_xfer - x0, 1);
      check("ib_addr", cap_addr, {ptr(r.sel), 20'h12345, r.lo});
      check("ib_ctl", {cap_wr, cap_sz, cap_be},
            {r.wr, r.sz, ~r.lane_n});
      check("ib_sup", cap_sup, i[0]);
      check("data", r.wr ? cap_wdata : q, r.d);
      check("wait", w, !r.wr);
      check("wait_pin", ext_wait_out, 1'b0);
    end
    // undefined byte pattern, then strobes without select
    x0 = n_xfer;
    m.access(1'b1, 1'b0, 1'b0, 24'h000000, 4'h5, 32'h0, q, w);
    check("bad_bc", n_xfer - x0, 0);
    m.access(1'b0, 1'b0, 1'b0, 24'h000000, 4'h0, 32'h0, q, w);
    check("no_sel", n_xfer - x0, 0);
    reg_wr(eib_pkg::EIB_CTRL_OFS, 32'h1);
    m.access(1'b1, 1'b0, 1'b1, 24'h000010, 4'h0, 32'h0, q, w);
    check("user", cap_sup, 1'b0);
    // outside pointer writes need the reconfig bit
    for (i = 0; i < 2; i++) begin
      reg_wr(eib_pkg::EIB_CTRL_OFS, i ? 32'h5 : 32'h1);
      m.access(1'b1, 1'b1, 1'b0, 24'h400000, 4'h0, 32'h155, q, w);
      reg_rd(eib_pkg::EIB_EXTCON_OFS, q);
      check("extcon", q, i ? 32'h155 : 32'h00200400);
    end
    m.access(1'b1, 1'b0, 1'b0, 24'h400000, 4'h0, 32'h0, q, w);
    check("cfg_rd", q, 32'h155);
    m.access(1'b1, 1'b0, 1'b0, 24'h000020, 4'h0, 32'h0, q, w);
    check("new_ptr", cap_addr, 32'h55400020);
    reg_wr(eib_pkg::EIB_EXTCON_OFS, 32'h00200400);
    // a slow target keeps the buffer full for the second write
    tgt_lat = 25;
    x0 = n_xfer;
    m.access(1'b1, 1'b1, 1'b0, 24'h000100, 4'h0, 32'h11, q, w);
    m.access(1'b1, 1'b1, 1'b0, 24'h000104, 4'h0, 32'h22, q, w2);
    check("wr_wait", {w, w2}, 2'h1);
    repeat (40) @(posedge clk);
    check("wr_cnt", n_xfer - x0, 2);
    check("wr_last", cap_wdata, 32'h22);
    // internal request arrives during an external read
    rej_seen = 1'b0;
    fork
      m.access(1'b1, 1'b0, 1'b0, 24'h000200, 4'h0, 32'h0, q, w);
      begin
        repeat (8) @(posedge clk);
        int_req <= 1'b1;
        @(negedge clk);
        check("own", ext_bus_own, 1'b1);
      end
    join
    check("reject", rej_seen, 1'b1);
    for (i = 0; i < 20 && int_grant !== 1'b1; i++) @(negedge clk);
    check("grant", int_grant, 1'b1);
    @(posedge clk);
    {int_req, int_done} <= 2'h1;
    @(posedge clk);
    int_done <= 1'b0;
    reg_wr(eib_pkg::EIB_EXTCON_OFS, 32'h40200400);
    repeat (2) @(negedge clk);
    check("lock", ib_lock, 1'b1);
    check("ungrant", int_grant, 1'b0);
    finish_test();
  end
endmodule

// file: testbench/eib_ext_master.sv
// external bus master model driving the bridge pins
`timescale 1ns/10ps
module eib_ext_master (
  // clock
  input wire logic        clk,
  // pins towards the bridge
  output logic            bridge_chip_select_n,
  output logic            ext_rd_n,
  output logic            ext_wr_n,
  output logic [23:0]     ext_addr,
  output logic [3:0]      byte_control_lines_n,
  output logic            privilege_level_pin,
  output logic [31:0]     ext_data_in,
  // pins from the bridge
  input wire logic [31:0] ext_data_out,
  input wire logic        ext_data_oe,
  input wire logic        ext_wait_oe
);
  // released lines float to their pull-up level
  task automatic release_bus();
    bridge_chip_select_n <= 1'b1;
    ext_rd_n             <= 1'b1;
    ext_wr_n             <= 1'b1;
    ext_addr             <= 24'hffffff;
    byte_control_lines_n <= 4'hf;
    privilege_level_pin  <= 1'b1;
    ext_data_in          <= 32'hffffffff;
  endtask
  initial release_bus();
  // one access, held until wait lets go or 80 cycles pass; no retry
  task automatic access(input logic sel, wr, pin,
                        input logic [23:0] a, input logic [3:0] lanes,
                        input logic [31:0] d,
                        output logic [31:0] q, output logic waited);
    int n;
    waited = 1'b0;
    @(posedge clk);
    bridge_chip_select_n <= !sel;
    ext_rd_n             <= wr;
    ext_wr_n             <= !wr;
    ext_addr             <= a;
    byte_control_lines_n <= lanes;
    privilege_level_pin  <= pin;
    ext_data_in          <= wr ? d : 32'hffffffff;
    for (n = 0; n < 80; n++) begin
      @(negedge clk);
      if (ext_wait_oe === 1'b1) waited = 1'b1;
      if (n > 5 && ext_wait_oe !== 1'b1
          && (wr || ext_data_oe === 1'b1)) break;
    end
    q = ext_data_out;
    @(posedge clk);
    release_bus();
    repeat (6) @(posedge clk);
  endtask
endmodule

// file: verilog/eib_bcdec.sv
// byte-control decoder: access width and low address bits
`timescale 1ns/10ps
module eib_bcdec (
  // active-low byte controls
  input  wire logic [3:0] lane_n,
  // decoded access
  output logic      [1:0] size,
  output logic      [1:0] addr_lo,
  output logic            valid
);

  // undefined patterns fall back to a word access and flag invalid
  always_comb begin
    size    = eib_pkg::EIB_SZ_WORD;
    addr_lo = 2'h0;
    valid   = 1'b1;
    case (lane_n)
      4'h0: size = eib_pkg::EIB_SZ_WORD;
      4'hc: size = eib_pkg::EIB_SZ_HALF;
      4'h3: begin
        size    = eib_pkg::EIB_SZ_HALF;
        addr_lo = 2'h2;
      end
      4'he: size = eib_pkg::EIB_SZ_BYTE;
      4'hd: begin
        size    = eib_pkg::EIB_SZ_BYTE;
        addr_lo = 2'h1;
      end
      4'hb: begin
        size    = eib_pkg::EIB_SZ_BYTE;
        addr_lo = 2'h2;
      end
      4'h7: begin
        size    = eib_pkg::EIB_SZ_BYTE;
        addr_lo = 2'h3;
      end
      default: valid = 1'b0;
    endcase
  end

endmodule

// file: verilog/eib_bridge.sv
// external-to-internal access bridge: external slave, internal bus master
`timescale 1ns/10ps
// What this block does
// - refuse external accesses unless enable set
// - issue privilege from pin when selected
// - external pointer reprogramming only with reconfig enable
// - lock bit keeps internal bus locked
// - 32-bit little-endian aligned target, byte writes
// - synchronise external inputs, two cycles
// - internal transfer lasts at least three cycles
// - read starts after address, strobes synchronised
// - write starts after data also synchronised
// - wait held on reads until data
// - writes buffered, wait only if buffer busy
// - one task at once, first-come first-served
// - reject internal requests while serving external
// - external access never aborted, master waits
// - bridge masters internal bus, no pass-through
// - ignore accesses without bridge chip select
// - prefix ten-bit pointer to external address
// - top address bits pick pointer or config
// - wait is output, address lines are inputs
module eib_bridge (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  // external bus, driven by the external master
  input  wire logic        bridge_chip_select_n,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  input  wire logic [23:0] ext_addr,
  input  wire logic [3:0]  byte_control_lines_n,
  input  wire logic        privilege_level_pin,
  input  wire logic [31:0] ext_data_in,
  // external bus, driven by the bridge
  output logic [31:0]      ext_data_out,
  output logic             ext_data_oe,
  output logic             ext_wait_out,
  output logic             ext_wait_oe,
  output logic             ext_bus_own,
  // internal bus master side
  output logic             ib_req,
  output logic [31:0]      ib_addr,
  output logic             ib_write,
  output logic [1:0]       ib_size,
  output logic [3:0]       ib_be,
  output logic [31:0]      ib_wdata,
  output logic             ib_supervisor,
  output logic             ib_lock,
  input  wire logic        ib_ack,
  input  wire logic [31:0] ib_rdata,
  // internal masters asking for the bridge
  input  wire logic        int_req,
  input  wire logic        int_done,
  output logic             int_grant,
  output logic             int_reject
);

  // synchronised external inputs
  logic [2:0]  s_ctl;
  logic [23:0] s_addr;
  logic [3:0]  s_lane_n;
  logic [31:0] s_data;
  logic        s_priv;
  logic        s_cs, s_rd, s_wr, acc_act, acc_prev_q, acc_new;

  // control and configuration
  logic [2:0]  ctrl_q;
  logic [29:0] ptr_q;
  logic        lock_q, refused_q;

  // pending external access
  logic        pend_q, pend_rd_q, pend_priv_q;
  logic [23:0] pend_addr_q;
  logic [3:0]  pend_lane_q;
  logic [31:0] pend_data_q;
  logic        done_now, refuse_now, cfg_wr_now, wb_load;
  logic        rd_imm, rd_from_ib;
  logic [31:0] rd_imm_data;
  logic [1:0]  pend_sel;
  logic        dec_valid;
  logic [1:0]  dec_size, dec_lo;

  // write buffer
  logic        wb_full_q, wb_priv_q;
  logic [31:0] wb_addr_q, wb_data_q;
  logic [3:0]  wb_be_q;
  logic [1:0]  wb_size_q;

  // transfer engine
  eib_pkg::eib_state_type state_q;
  logic [1:0]  cnt_q;
  logic        xfer_rd_q, xfer_done;
  logic [31:0] ext_addr32;

  // all external inputs pass the same two stages together
  eib_sync #(.W(3)) u_sync_ctl (
    .clk  (clk),
    .rstn (rstn),
    .d    ({~bridge_chip_select_n, ~ext_rd_n, ~ext_wr_n}),
    .q    (s_ctl)
  );
  eib_sync #(.W(61)) u_sync_dat (
    .clk  (clk),
    .rstn (rstn),
    .d    ({privilege_level_pin, byte_control_lines_n, ext_addr,
            ext_data_in}),
    .q    ({s_priv, s_lane_n, s_addr, s_data})
  );

  assign s_cs    = s_ctl[2];
  assign s_rd    = s_ctl[1];
  assign s_wr    = s_ctl[0];
  assign acc_act = s_cs & (s_rd | s_wr);
  assign acc_new = acc_act & ~acc_prev_q;

  eib_bcdec u_bcdec (
    .lane_n  (pend_lane_q),
    .size    (dec_size),
    .addr_lo (dec_lo),
    .valid   (dec_valid)
  );

  // pointer prefix chosen by the top address bits
  assign pend_sel = pend_addr_q[23:22];
  always_comb begin
    case (pend_sel)
      eib_pkg::EIB_SEL_B:
        ext_addr32 = {ptr_q[eib_pkg::EIB_PTR_B_LSB +: eib_pkg::EIB_PTR_W],
                      pend_addr_q[21:2], dec_lo};
      eib_pkg::EIB_SEL_C:
        ext_addr32 = {ptr_q[eib_pkg::EIB_PTR_C_LSB +: eib_pkg::EIB_PTR_W],
                      pend_addr_q[21:2], dec_lo};
      default:
        ext_addr32 = {ptr_q[eib_pkg::EIB_PTR_A_LSB +: eib_pkg::EIB_PTR_W],
                      pend_addr_q[21:2], dec_lo};
    endcase
  end

  // decide how the pending access is finished without the internal bus
  always_comb begin
    refuse_now  = 1'b0;
    cfg_wr_now  = 1'b0;
    wb_load     = 1'b0;
    rd_imm      = 1'b0;
    rd_imm_data = 32'h0000_0000;
    if (pend_q) begin
      if (!ctrl_q[eib_pkg::EIB_CTRL_ACC_BIT] || !dec_valid) begin
        refuse_now = 1'b1;
        rd_imm     = pend_rd_q;
      end else if (pend_sel == eib_pkg::EIB_SEL_CFG) begin
        if (!ctrl_q[eib_pkg::EIB_CTRL_RECON_BIT]) begin
          refuse_now = 1'b1;
          rd_imm     = pend_rd_q;
        end else if (pend_rd_q) begin
          rd_imm      = 1'b1;
          rd_imm_data = {1'b0, lock_q, ptr_q};
        end else begin
          cfg_wr_now = 1'b1;
        end
      end else if (!pend_rd_q && !wb_full_q) begin
        wb_load = 1'b1;
      end
    end
  end

  assign rd_from_ib = xfer_done & xfer_rd_q;
  assign done_now   = refuse_now | cfg_wr_now | wb_load | rd_imm |
                      rd_from_ib;

  // capture one access at a time; it stays until served, never dropped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_prev_q  <= 1'b0;
      pend_q      <= 1'b0;
      pend_rd_q   <= 1'b0;
      pend_priv_q <= 1'b0;
      pend_addr_q <= 24'h00_0000;
      pend_lane_q <= 4'hf;
      pend_data_q <= 32'h0000_0000;
    end else begin
      acc_prev_q <= acc_act;
      if (acc_new) begin
        pend_q      <= 1'b1;
        pend_rd_q   <= s_rd;
        pend_priv_q <= s_priv;
        pend_addr_q <= s_addr;
        pend_lane_q <= s_lane_n;
        pend_data_q <= s_data;
      end else if (done_now) begin
        pend_q <= 1'b0;
      end
    end
  end

  // wait: reads until data, writes only while the buffer is busy
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_wait_oe  <= 1'b0;
      ext_wait_out <= 1'b0;
    end else begin
      ext_wait_out <= 1'b0; // open drain, only ever pulls low
      if (acc_new) begin
        ext_wait_oe <= s_rd | wb_full_q;
      end else if (done_now) begin
        ext_wait_oe <= 1'b0;
      end else begin
        ext_wait_oe <= pend_q & (pend_rd_q | wb_full_q);
      end
    end
  end

  // read data stand on the bus until the master lets the strobe go
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_data_out <= 32'h0000_0000;
      ext_data_oe  <= 1'b0;
    end else begin
      if (rd_from_ib) begin
        ext_data_out <= ib_rdata;
        ext_data_oe  <= 1'b1;
      end else if (rd_imm) begin
        ext_data_out <= rd_imm_data;
        ext_data_oe  <= 1'b1;
      end else if (!(s_cs && s_rd)) begin
        ext_data_oe <= 1'b0;
      end
    end
  end

  // buffered write, filled from the pending access
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_full_q <= 1'b0;
      wb_priv_q <= 1'b0;
      wb_addr_q <= 32'h0000_0000;
      wb_data_q <= 32'h0000_0000;
      wb_be_q   <= 4'h0;
      wb_size_q <= eib_pkg::EIB_SZ_WORD;
    end else begin
      if (wb_load) begin
        wb_full_q <= 1'b1;
        wb_priv_q <= pend_priv_q;
        wb_addr_q <= ext_addr32;
        wb_data_q <= pend_data_q;
        wb_be_q   <= ~pend_lane_q;
        wb_size_q <= dec_size;
      end else if (xfer_done && !xfer_rd_q) begin
        wb_full_q <= 1'b0;
      end
    end
  end

  assign xfer_done = (state_q == eib_pkg::EIB_XFER) && ib_ack &&
                     (cnt_q >= eib_pkg::EIB_IB_LAST);

  // one task at a time: buffered write, then read, then internal request
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q   <= eib_pkg::EIB_IDLE;
      cnt_q     <= 2'h0;
      xfer_rd_q <= 1'b0;
      int_grant <= 1'b0;
    end else begin
      case (state_q)
        eib_pkg::EIB_IDLE: begin
          cnt_q <= 2'h0;
          if (wb_full_q) begin
            state_q   <= eib_pkg::EIB_XFER;
            xfer_rd_q <= 1'b0;
          end else if (pend_q && pend_rd_q && !rd_imm) begin
            state_q   <= eib_pkg::EIB_XFER;
            xfer_rd_q <= 1'b1;
          end else if (int_req && !pend_q && !acc_act) begin
            state_q   <= eib_pkg::EIB_INT;
            int_grant <= 1'b1;
          end
        end
        eib_pkg::EIB_XFER: begin
          if (cnt_q != eib_pkg::EIB_IB_LAST) begin
            cnt_q <= cnt_q + 2'h1;
          end
          if (xfer_done) begin
            state_q <= eib_pkg::EIB_IDLE;
          end
        end
        eib_pkg::EIB_INT: begin
          if (int_done) begin
            state_q   <= eib_pkg::EIB_IDLE;
            int_grant <= 1'b0;
          end
        end
        default: state_q <= eib_pkg::EIB_IDLE;
      endcase
    end
  end

  // internal bus request, held stable for the whole transfer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ib_req        <= 1'b0;
      ib_addr       <= 32'h0000_0000;
      ib_write      <= 1'b0;
      ib_size       <= eib_pkg::EIB_SZ_WORD;
      ib_be         <= 4'h0;
      ib_wdata      <= 32'h0000_0000;
      ib_supervisor <= 1'b0;
    end else if (state_q == eib_pkg::EIB_IDLE) begin
      if (wb_full_q) begin
        ib_req        <= 1'b1;
        ib_addr       <= wb_addr_q;
        ib_write      <= 1'b1;
        ib_size       <= wb_size_q;
        ib_be         <= wb_be_q;
        ib_wdata      <= wb_data_q;
        ib_supervisor <= wb_priv_q &
                         ctrl_q[eib_pkg::EIB_CTRL_PRIV_BIT];
      end else if (pend_q && pend_rd_q && !rd_imm) begin
        ib_req        <= 1'b1;
        ib_addr       <= ext_addr32;
        ib_write      <= 1'b0;
        ib_size       <= dec_size;
        ib_be         <= ~pend_lane_q;
        ib_supervisor <= pend_priv_q &
                         ctrl_q[eib_pkg::EIB_CTRL_PRIV_BIT];
      end
    end else if (xfer_done) begin
      ib_req <= 1'b0;
    end
  end

  // ownership and rejection while an external access is in hand
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_bus_own <= 1'b0;
      int_reject  <= 1'b0;
      ib_lock     <= 1'b0;
    end else begin
      ext_bus_own <= pend_q | acc_act | wb_full_q |
                     (state_q == eib_pkg::EIB_XFER);
      int_reject  <= int_req & ~int_grant &
                     (pend_q | acc_act | wb_full_q |
                      (state_q != eib_pkg::EIB_IDLE));
      ib_lock     <= lock_q;
    end
  end

  // control, pointer and status registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q    <= eib_pkg::EIB_CTRL_RST;
      ptr_q     <= {eib_pkg::EIB_PTR_C_RST, eib_pkg::EIB_PTR_B_RST,
                    eib_pkg::EIB_PTR_A_RST};
      lock_q    <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (reg_we && reg_addr == eib_pkg::EIB_CTRL_OFS) begin
        ctrl_q <= reg_wdata[2:0];
      end
      if (cfg_wr_now) begin
        ptr_q  <= pend_data_q[29:0];
        lock_q <= pend_data_q[eib_pkg::EIB_LOCK_BIT];
      end else if (reg_we && reg_addr == eib_pkg::EIB_EXTCON_OFS) begin
        ptr_q  <= reg_wdata[29:0];
        lock_q <= reg_wdata[eib_pkg::EIB_LOCK_BIT];
      end
      // a refusal in the clearing cycle still sets the flag
      if (refuse_now) begin
        refused_q <= 1'b1;
      end else if (reg_we && reg_addr == eib_pkg::EIB_STAT_OFS &&
                   reg_wdata[eib_pkg::EIB_STAT_REFUSE_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // read data one cycle after the read strobe, zero when unmapped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_re) begin
      case (reg_addr)
        eib_pkg::EIB_CTRL_OFS:   reg_rdata <= {29'h0, ctrl_q};
        eib_pkg::EIB_EXTCON_OFS: reg_rdata <= {1'b0, lock_q, ptr_q};
        eib_pkg::EIB_STAT_OFS:
          reg_rdata <= {29'h0, refused_q, wb_full_q,
                        state_q != eib_pkg::EIB_IDLE};
        default:                 reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: verilog/eib_sync.sv
// two-stage synchroniser for the external strobes, address and data
`timescale 1ns/10ps
module eib_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
